// ---- rtl/ddrfe_top.v ----
// Purpose: DDR2 device-side control front end (command sampling, power states,
//          termination, write masking, bank decode)
// Assumes: ck and ck_n arrive asynchronously; sampled by clock through two flops
// Notes: read strobe output follows each crossing of the sampled clock pair on which read data is valid;
//        write beats that find a free entry wait in a two-entry buffer until the consumer takes them;
//        power state 0 idle, 1 and 2 power-down, 3 self refresh
`timescale 1ns/100ps
`include "ddrfe_consts.vh"
module ddrfe_top #(
  parameter ADDR_W = 13,
  parameter BA_W   = 3,
  parameter DQ_W   = 16
) (
  input  wire              clock,
  input  wire              rst_n,
  input  wire              ck,
  input  wire              ck_n,
  input  wire              cke,
  input  wire              cs_n,
  input  wire              ras_n,
  input  wire              cas_n,
  input  wire              we_n,
  input  wire [BA_W-1:0]   ba,
  input  wire [ADDR_W-1:0] addr,
  input  wire              odt,
  input  wire              dqs_in,
  input  wire [DQ_W-1:0]   dq_in,
  input  wire              upper_byte_write_mask,
  input  wire              lower_byte_write_mask,
  input  wire [DQ_W-1:0]   rd_data,
  input  wire              rd_valid,
  output wire              rd_ready,
  input  wire              wr_ready,
  output wire              wr_valid,
  output reg  [DQ_W-1:0]   wr_data,
  output reg  [1:0]        wr_byte_en,
  output reg               cmd_valid,
  output reg  [3:0]        cmd_code,
  output reg  [BA_W-1:0]   cmd_bank,
  output reg  [ADDR_W-1:0] cmd_addr,
  output reg               cmd_all_banks,
  output reg  [ADDR_W-1:0] mode_reg,
  output reg  [ADDR_W-1:0] ext_mode_reg,
  output reg  [1:0]        power_state,
  output reg               clk_run,
  output reg               rx_data_en,
  output reg               rx_ck_en,
  output reg               term_on,
  output reg  [DQ_W-1:0]   dq_out,
  output reg  [DQ_W-1:0]   dq_oe,
  output reg               upper_byte_strobe,
  output reg               lower_byte_strobe,
  output reg               strobe_oe,
  output reg               strobe_n_oe
);

  reg rst_m_q, rst_s_q;
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_m_q <= 1'b0;
      rst_s_q <= 1'b0;
    end else begin
      rst_m_q <= 1'b1;
      rst_s_q <= rst_m_q;
    end
  end

  // Two-flop synchronisers for every pin
  localparam SW = 9 + BA_W + ADDR_W + 1 + DQ_W + 2;
  wire [SW-1:0] pin_raw = {ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_in,
                           ba, addr, 1'b0, dq_in,
                           upper_byte_write_mask, lower_byte_write_mask};
  reg  [SW-1:0] pin_m_q, pin_s_q;
  genvar si;
  generate
    for (si = 0; si < SW; si = si + 1) begin : g_sync
      always @(posedge clock or negedge rst_s_q) begin
        if (!rst_s_q) begin
          pin_m_q[si] <= 1'b0;
          pin_s_q[si] <= 1'b0;
        end else begin
          pin_m_q[si] <= pin_raw[si];
          pin_s_q[si] <= pin_m_q[si];
        end
      end
    end
  endgenerate

  // Field positions in the synchronised pin vector
  localparam P_CK   = SW - 1;
  localparam P_CKN  = SW - 2;
  localparam P_CKE  = SW - 3;
  localparam P_CMD  = SW - 4;
  localparam P_ODT  = SW - 8;
  localparam P_DQS  = SW - 9;
  localparam P_BA   = SW - 10;
  localparam P_ADDR = SW - 10 - BA_W;
  localparam P_DQ   = DQ_W + 1;
  localparam P_DM   = 1;

  wire              ck_s   = pin_s_q[P_CK];
  wire              ckn_s  = pin_s_q[P_CKN];
  wire              cke_s  = pin_s_q[P_CKE];
  wire [3:0]        cmd_s  = pin_s_q[P_CMD -: 4];
  wire              odt_s  = pin_s_q[P_ODT];
  wire              dqs_s  = pin_s_q[P_DQS];
  wire [BA_W-1:0]   ba_s   = pin_s_q[P_BA -: BA_W];
  wire [ADDR_W-1:0] addr_s = pin_s_q[P_ADDR -: ADDR_W];
  wire [DQ_W-1:0]   dq_s   = pin_s_q[P_DQ -: DQ_W];
  wire [1:0]        dm_s   = pin_s_q[P_DM -: 2];


  reg ck_prev_q, ckn_prev_q, dqs_prev_q;
  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      ck_prev_q  <= 1'b0;
      ckn_prev_q <= 1'b1;
      dqs_prev_q <= 1'b0;
    end else begin
      ck_prev_q  <= ck_s;
      ckn_prev_q <= ckn_s;
      dqs_prev_q <= dqs_s;
    end
  end
  wire xr = ck_s & ~ck_prev_q & (~ckn_s | ckn_prev_q);
  wire xf = ~ck_s & ck_prev_q;
  wire dqs_edge = dqs_s ^ dqs_prev_q;

  reg [`DDRFE_BANKS-1:0] open_q;
  reg                    wr_act_q, rd_act_q;
  wire                   dqsn_en = ~ext_mode_reg[`DDRFE_EMR_DQSN];
  wire                   pd_st   = (power_state != `DDRFE_ST_IDLE);
  // clocks still watched in power-down, but not in self refresh
  wire                   ck_ok   = (power_state != `DDRFE_ST_SREF);
  wire                   xr_ok   = xr & ck_ok;

  // Power state machine
  reg [1:0] power_state_d;
  always @* begin
    power_state_d = power_state;
    case (power_state)
      `DDRFE_ST_IDLE: begin
        // entry sampled on crossing; state by bank status, then refresh command
        if (xr && !cke_s) begin
          if (open_q != {`DDRFE_BANKS{1'b0}})
            power_state_d = `DDRFE_ST_APD;
          else if (cmd_s == `DDRFE_CMD_REF)
            power_state_d = `DDRFE_ST_SREF;
          else
            power_state_d = `DDRFE_ST_PPD;
        end
      end
      `DDRFE_ST_PPD, `DDRFE_ST_APD: begin
        if (xr && cke_s)
          power_state_d = `DDRFE_ST_IDLE;
      end
      `DDRFE_ST_SREF: begin
        if (cke_s)
          power_state_d = `DDRFE_ST_IDLE;
      end
      default: power_state_d = `DDRFE_ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      power_state <= `DDRFE_ST_IDLE;
    end else begin
      power_state <= power_state_d;
    end
  end

  // internal clocks and buffers follow clock enable and state
  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      clk_run    <= 1'b0;
      rx_data_en <= 1'b0;
      rx_ck_en   <= 1'b1;
    end else begin
      clk_run    <= cke_s & ~pd_st;
      // data, command and address receivers off in power-down
      rx_data_en <= cke_s & ~pd_st;
      // clock receivers off in self refresh
      rx_ck_en   <= ck_ok;
    end
  end

  // chip select masks; reads and writes assume clock enable held
  wire cmd_take = xr_ok && cke_s && !pd_st && !cmd_s[3];

  // termination gate sees an opcode written on this same crossing
  reg [ADDR_W-1:0] ext_mode_d;
  always @* begin
    ext_mode_d = ext_mode_reg;
    if (cmd_take && (cmd_s == `DDRFE_CMD_MRS) && ba_s[0])
      ext_mode_d = addr_s;
  end
  wire rtt_en_d = ext_mode_d[`DDRFE_EMR_RTT0] | ext_mode_d[`DDRFE_EMR_RTT1];

  // one open-row flag per bank; address bit ten closes all
  genvar gi;
  generate
    for (gi = 0; gi < `DDRFE_BANKS; gi = gi + 1) begin : g_bank
      localparam [BA_W-1:0] BANK_ID = gi;
      wire hit = (ba_s == BANK_ID);
      always @(posedge clock or negedge rst_s_q) begin
        if (!rst_s_q) begin
          open_q[gi] <= 1'b0;
        end else if (cmd_take) begin
          if ((cmd_s == `DDRFE_CMD_ACT) && hit)
            open_q[gi] <= 1'b1;
          else if ((cmd_s == `DDRFE_CMD_PRE) && (addr_s[`DDRFE_AP_BIT] || hit))
            open_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      cmd_valid     <= 1'b0;
      cmd_code      <= `DDRFE_CMD_NOP;
      cmd_bank      <= {BA_W{1'b0}};
      cmd_addr      <= {ADDR_W{1'b0}};
      cmd_all_banks <= 1'b0;
      mode_reg      <= {ADDR_W{1'b0}};
      ext_mode_reg  <= {ADDR_W{1'b0}};
      term_on       <= 1'b0;
    end else begin
      cmd_valid <= cmd_take;
      if (xr_ok) begin
        // registered termination; gated by extended mode
        term_on <= odt_s & rtt_en_d & ~pd_st;
      end
      if (cmd_take) begin
        cmd_code      <= cmd_s;
        cmd_bank      <= ba_s;
        cmd_addr      <= addr_s;
        cmd_all_banks <= (cmd_s == `DDRFE_CMD_PRE) & addr_s[`DDRFE_AP_BIT];
        case (cmd_s)
          `DDRFE_CMD_MRS: begin
            // low bank bit picks register; opcode from address
            if (ba_s[0])
              ext_mode_reg <= addr_s;
            else
              mode_reg <= addr_s;
          end
          default: mode_reg <= mode_reg;
        endcase
      end
    end
  end

  // Write beat capture into two-entry buffer
  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      wr_act_q <= 1'b0;
      rd_act_q <= 1'b0;
    end else begin
      if (cmd_take)
        wr_act_q <= (cmd_s == `DDRFE_CMD_WR);
      if (cmd_take)
        rd_act_q <= (cmd_s == `DDRFE_CMD_RD);
    end
  end

  reg [DQ_W+1:0] buf_q [0:1];
  reg            wp_q, rp_q;
  reg [1:0]      cnt_q;
  wire           beat_in = wr_act_q & dqs_edge & rx_data_en;
  wire           push    = beat_in & (cnt_q != 2'h2);
  wire           pop     = wr_valid & wr_ready;
  assign wr_valid = (cnt_q != 2'h0);
  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      wp_q  <= 1'b0;
      rp_q  <= 1'b0;
      cnt_q <= 2'h0;
      buf_q[0] <= {(DQ_W+2){1'b0}};
      buf_q[1] <= {(DQ_W+2){1'b0}};
    end else begin
      if (push) begin
        // inverted mask bits become byte enables; masked bytes are still stored
        buf_q[wp_q] <= {~dm_s, dq_s};
        wp_q <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      case ({push, pop})
        2'b10:   cnt_q <= cnt_q + 2'h1;
        2'b01:   cnt_q <= cnt_q - 2'h1;
        default: cnt_q <= cnt_q;
      endcase
    end
  end
  always @* begin
    wr_data    = buf_q[rp_q][DQ_W-1:0];
    wr_byte_en = buf_q[rp_q][DQ_W+1:DQ_W];
  end


  // Read path driven on both crossings
  assign rd_ready = rd_act_q & (xr | xf) & clk_run;
  always @(posedge clock or negedge rst_s_q) begin
    if (!rst_s_q) begin
      dq_out            <= {DQ_W{1'b0}};
      dq_oe             <= {DQ_W{1'b0}};
      upper_byte_strobe <= 1'b0;
      lower_byte_strobe <= 1'b0;
      strobe_oe         <= 1'b0;
      strobe_n_oe       <= 1'b0;
    end else begin
      if (rd_ready && rd_valid) begin
        // data and strobe change on the same crossing
        dq_out            <= rd_data;
        upper_byte_strobe <= xr;
        lower_byte_strobe <= xr;
      end
      // drivers off while clock enable low
      dq_oe       <= {DQ_W{rd_act_q & clk_run}};
      strobe_oe   <= rd_act_q & clk_run;
      // one bit gates all complementary strobes
      strobe_n_oe <= rd_act_q & clk_run & dqsn_en;
    end
  end
  // term_on applies to data, strobes and masks at the pad ring only

endmodule // ddrfe_top

// ---- rtl/ddrfe_consts.vh ----
// Purpose: constants for the DDR2 pin control front end
// Assumes: 100 MHz system clock samples all pins
// Notes: command codes are {cs_n, ras_n, cas_n, we_n}
`ifndef DDRFE_CONSTS_VH
`define DDRFE_CONSTS_VH
`define DDRFE_CMD_MRS     4'h0
`define DDRFE_CMD_REF     4'h1
`define DDRFE_CMD_PRE     4'h2
`define DDRFE_CMD_ACT     4'h3
`define DDRFE_CMD_WR      4'h4
`define DDRFE_CMD_RD      4'h5
`define DDRFE_CMD_NOP     4'h7
`define DDRFE_AP_BIT      10
`define DDRFE_EMR_RTT0    2
`define DDRFE_EMR_RTT1    6
`define DDRFE_EMR_DQSN    10
`define DDRFE_ST_IDLE     2'h0
`define DDRFE_ST_PPD      2'h1
`define DDRFE_ST_APD      2'h2
`define DDRFE_ST_SREF     2'h3
`define DDRFE_BANKS       8
`endif

// ---- verification/ddrfe_monitor.sv ----
// Purpose: output checks for ddrfe_top
// Assumes: power_state 0 idle, 1 and 2 power-down, 3 self refresh
// Notes: bound into the top module
`timescale 1ns/100ps
module ddrfe_monitor #(parameter ADDR_W = 13) (
  input wire              clock,
  input wire              rst_n,
  input wire              cke,
  input wire              cmd_valid,
  input wire [3:0]        cmd_code,
  input wire [ADDR_W-1:0] cmd_addr,
  input wire              cmd_all_banks,
  input wire [ADDR_W-1:0] ext_mode_reg,
  input wire [1:0]        power_state,
  input wire              rx_data_en,
  input wire              rx_ck_en,
  input wire              term_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  pulse_once_a: assert property (cmd_valid |=> !cmd_valid) else $error("cmd held");
  select_mask_a: assert property (cmd_valid |-> !cmd_code[3]) else $error("deselected");
  pd_no_cmd_a: assert property ($stable(power_state) && power_state != 2'h0
    |-> !cmd_valid) else $error("cmd in power down");
  pd_receivers_a: assert property ($stable(power_state) && power_state inside {2'h1, 2'h2}
    |-> rx_ck_en && !rx_data_en) else $error("power down receivers");
  sref_receivers_a: assert property ($stable(power_state) && power_state == 2'h3
    |-> !rx_ck_en && !rx_data_en) else $error("self refresh receivers");
  term_gate_a: assert property (term_on && $stable(ext_mode_reg)
    |-> ext_mode_reg[2] || ext_mode_reg[6]) else $error("termination ungated");
  all_banks_a: assert property (cmd_valid && cmd_code == 4'h2
    |-> cmd_all_banks == cmd_addr[10]) else $error("precharge scope");
  sref_exit_a: assert property (power_state == 2'h3 && $rose(cke)
    |-> ##[1:8] power_state == 2'h0) else $error("self refresh exit");
  cover property (cmd_valid && cmd_code == 4'h4);
  cover property (power_state == 2'h2);
  cover property (term_on);
endmodule // ddrfe_monitor
bind ddrfe_top ddrfe_monitor #(.ADDR_W(ADDR_W)) u_mon (.clock, .rst_n, .cke, .cmd_valid,
  .cmd_code, .cmd_addr, .cmd_all_banks, .ext_mode_reg, .power_state, .rx_data_en, .rx_ck_en,
  .term_on);

// ---- verification/ddrfe_ctrl_model.sv ----
// Purpose: controller model for clock pair and command pins
// Assumes: one command slot per clock pair period
// Notes: released command pins go high; bank and address show the inverse of the last value
`timescale 1ns/100ps
module ddrfe_ctrl_model (
  output logic        ck,
  output wire         ck_n,
  output logic        cke,
  output logic        cs_n,
  output logic        ras_n,
  output logic        cas_n,
  output logic        we_n,
  output logic [2:0]  ba,
  output logic [12:0] addr
);
  logic run = 1'h1;
  initial {ck, cke, cs_n, ras_n, cas_n, we_n, ba, addr} = {2'h1, 4'hf, 16'h0};
  always #62.5 if (run) ck = ~ck;
  assign ck_n = ~ck;
  // enable moves at a slot in issue, or at once in pins
  task automatic issue(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                       input logic k);
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = c;
    {ba, addr, cke} = {b, a, k};
    @(negedge ck);
    {cs_n, ras_n, cas_n, we_n} = 4'hf;
    {ba, addr} = ~{b, a};
  endtask
  task automatic pins(input logic r, input logic k);
    {run, cke} = {r, k};
  endtask
endmodule // ddrfe_ctrl_model

// ---- verification/ddr2_dram_pin_control_front_end_test.sv ----
// Purpose: self-checking bench for the pin control front end
// Assumes: controller model drives clock pair and commands
// Notes: drivers queue expected words, watchers pop them
`timescale 1ns/100ps
module ddr2_dram_pin_control_front_end_test;
  logic clock = 1'h0, rst_n = 1'h0, odt = 1'h0, dqs_in = 1'h0, rd_valid = 1'h0;
  logic wr_ready = 1'h0, stall = 1'h1, upper_byte_write_mask = 1'h0, lower_byte_write_mask = 1'h0;
  logic [15:0] dq_in = 16'h0, rd_data = 16'h0;
  logic [19:0] cq[$], wq[$];
  logic [12:0] r;
  logic [3:0]  ops[4] = '{4'h3, 4'h5, 4'h4, 4'h2};
  int cmp_count = 0, miscompares = 0, cyc = 0;
  wire ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, rd_ready, wr_valid, cmd_valid, cmd_all_banks;
  wire clk_run, rx_data_en, rx_ck_en, term_on, upper_byte_strobe, lower_byte_strobe;
  wire strobe_oe, strobe_n_oe;
  wire [1:0]  wr_byte_en, power_state;
  wire [2:0]  ba, cmd_bank;
  wire [3:0]  cmd_code;
  wire [12:0] addr, cmd_addr, mode_reg, ext_mode_reg;
  wire [15:0] wr_data, dq_out, dq_oe;
  ddrfe_top i_dut (.*);
  ddrfe_ctrl_model i_ctrl (.*);
  always #5 clock = ~clock;
  always @(posedge clock) begin
    rd_valid <= #1 1'($urandom);
    rd_data <= #1 16'($urandom);
    wr_ready <= #1 !stall && 1'($urandom);
    if (++cyc == 20000) begin
      miscompares++;
      close_out();
    end
  end
  always @(posedge clock) begin
    if (cmd_valid === 1'h1)
      check("cmd", cq.size() ? cq.pop_front() : 20'hx, {cmd_code, cmd_bank, cmd_addr});
    if (wr_valid === 1'h1 && wr_ready === 1'h1)
      check("wr", wq.size() ? wq.pop_front() : 20'hx, {2'h0, wr_byte_en, wr_data});
  end
  task automatic check(input string n, input logic [19:0] e, s);
    cmp_count++;
    if (s !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cmd(input logic [3:0] c, input logic [2:0] b, input logic [12:0] a,
                     input logic k);
    if (!c[3] && k) cq.push_back({c, b, a});
    i_ctrl.issue(c, b, a, k);
  endtask
  task automatic settle();
    repeat (40) @(posedge clock);
    #1;
  endtask
  task automatic beat(input logic [1:0] m, input logic keep);
    logic [15:0] d;
    d = 16'($urandom);
    @(posedge clock) #1;
    {upper_byte_write_mask, lower_byte_write_mask, dq_in} = {m, d};
    repeat (3) @(posedge clock);
    #1 dqs_in = ~dqs_in;
    if (keep) wq.push_back({2'h0, ~m, d});
    repeat (4) @(posedge clock);
    #1 dq_in = ~d;
  endtask
  task automatic close_out();
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    void'($urandom(21));
    repeat (3) @(posedge clock);
    #1 rst_n = 1'h1;
    repeat (8) @(posedge clock);
    r = 13'($urandom);
    cmd(4'h0, 3'h1, 13'h0004, 1'h1);
    cmd(4'h0, 3'h0, r, 1'h1);
    settle();
    check("mode", {ext_mode_reg, 7'h0}, 20'h00200);
    check("mode", 20'(mode_reg), 20'(r));
    for (int i = 1; i >= 0; i--) begin
      odt = i[0];
      settle();
      check("term", 20'(term_on), 20'(i));
    end
    for (int i = 0; i < 8; i++) begin
      cmd(ops[i % 4], 3'(i), 13'($urandom), 1'h1);
      if (i % 4 == 1) check("read drive", 20'({strobe_oe, strobe_n_oe, dq_oe}), 20'h3ffff);
      cmd(ops[i % 4] | 4'h8, 3'(i), 13'($urandom), 1'h1);
    end
    for (int i = 0; i < 2; i++) begin
      cmd(4'h2, 3'h0, 13'h0400, 1'h1);
      if (i == 1) cmd(4'h3, 3'h2, 13'h0, 1'h1);
      cmd(4'hf, 3'h0, 13'h0, 1'h0);
      settle();
      check("pd", 20'({power_state, rx_ck_en, rx_data_en}), i ? 20'ha : 20'h6);
      cmd(4'hf, 3'h0, 13'h0, 1'h1);
      settle();
      check("pd exit", 20'({power_state, clk_run, rx_data_en}), 20'h3);
    end
    cmd(4'h2, 3'h0, 13'h0400, 1'h1);
    cmd(4'h0, 3'h1, 13'h0, 1'h1);
    odt = 1'h1;
    settle();
    check("term", 20'(term_on), 20'h0);
    odt = 1'h0;
    cmd(4'h1, 3'h0, 13'h0, 1'h0);
    settle();
    check("sref", 20'({power_state, rx_ck_en, rx_data_en}), 20'hc);
    i_ctrl.pins(1'h0, 1'h0);
    settle();
    i_ctrl.pins(1'h0, 1'h1);
    settle();
    check("sref exit", 20'(power_state), 20'h0);
    i_ctrl.pins(1'h1, 1'h1);
    settle();
    cmd(4'h4, 3'h5, 13'h0010, 1'h1);
    beat(2'h1, 1'h1);
    beat(2'h2, 1'h1);
    beat(2'h0, 1'h0);
    check("full", 20'(wr_valid), 20'h1);
    stall = 1'h0;
    settle();
    check("empty", 20'(wr_valid), 20'h0);
    cmd(4'h4, 3'h6, 13'h0020, 1'h1);
    repeat (2) beat(2'($urandom_range(2)), 1'h1);
    settle();
    check("left", 20'(cq.size() + wq.size()), 20'h0);
    close_out();
  end
endmodule // ddr2_dram_pin_control_front_end_test
